/* File: design/btob_core.sv */
// decode and execute of bit invert, overflow branch and skip on bit set
`timescale 1ns/1ps
module btob_core (
  input  wire logic                 clk_sys,
  input  wire logic                 reset,
  input  wire btob_pkg::btob_instr_s instr,
  input  wire logic [20:0]          pc_in,
  input  wire logic [3:0]           bank_select_reg,
  input  wire logic                 ext_set_en,
  input  wire logic [7:0]           fsr2_base,
  input  wire logic                 overflow_flag,
  input  wire logic [7:0]           mem_rdata,
  output btob_pkg::btob_mem_s       mem,
  output logic [20:0]               pc_target,
  output logic                      pc_load,
  output logic                      flush,
  output logic [1:0]                phase,
  output logic                      status_we
);
  import btob_pkg::*;

  btob_state_s st_reg;
  btob_state_s st_next;

  // ============================================================
  // address resolution
  function automatic logic [11:0] resolve(input logic [7:0] f,
                                          input logic a);
    if (a) begin
      resolve = {bank_select_reg, f};
    end else if (ext_set_en && f <= BTOB_INDEX_LIMIT) begin
      resolve = {4'h0, fsr2_base + f};
    end else if (f >= BTOB_ACCESS_SPLIT) begin
      resolve = BTOB_ACCESS_HI | {4'h0, f};
    end else begin
      resolve = {4'h0, f};
    end
  endfunction

  function automatic logic [20:0] branch_to(input logic [20:0] pc,
                                            input logic [7:0] n);
    branch_to = pc + BTOB_PC_STEP
              + {{12{n[7]}}, n, 1'b0};
  endfunction

  logic is_invert;
  logic is_branch;
  logic is_skip;
  logic [11:0] op_addr;
  logic [7:0]  bit_mask;
  logic        at_decide;
  logic        skip_hit;

  assign is_invert = st_reg.ir[15:12] == BTOB_OP_INVERT;
  assign is_branch = st_reg.ir[15:8] == BTOB_OP_BRANCH;
  assign is_skip   = st_reg.ir[15:12] == BTOB_OP_SKIP;
  assign op_addr   = resolve(st_reg.ir[7:0], st_reg.ir[8]);
  assign bit_mask  = 8'h01 << st_reg.ir[11:9];
  assign at_decide = st_reg.mode == BTOB_EXEC
                     && st_reg.phase == BTOB_PHASE_LAST;
  assign skip_hit  = is_skip && (st_reg.rdata & bit_mask) != 8'h00;

  // ============================================================
  // next state
  always_comb begin
    st_next = st_reg;
    st_next.phase = st_reg.phase + 2'h1;
    if (st_reg.phase == BTOB_PHASE_LAST) begin
      st_next.pc_load = 1'b0;
      st_next.flush = 1'b0;
      case (st_reg.mode)
        BTOB_FLUSH2: begin
          st_next.mode = BTOB_FLUSH;
          st_next.flush = 1'b1;
        end
        default: begin
          st_next.mode = BTOB_EXEC;
          st_next.ir = instr.valid ? instr.word : 16'h0000;
        end
      endcase
    end
    if (st_reg.phase == 2'h0 && st_reg.mode == BTOB_EXEC) begin
      st_next.ir = instr.valid ? instr.word : 16'h0000;
    end
    if (st_reg.mode == BTOB_EXEC && st_reg.phase == BTOB_PHASE_READ) begin
      st_next.rdata = mem_rdata;
    end
    if (st_reg.mode == BTOB_EXEC && st_reg.phase == BTOB_PHASE_LAST) begin
      if (st_reg.ir[15:8] == BTOB_OP_BRANCH && overflow_flag) begin
        st_next.pc = branch_to(pc_in, st_reg.ir[7:0]);
        st_next.pc_load = 1'b1;
        st_next.flush = 1'b1;
        st_next.mode = BTOB_FLUSH;
      end else if (st_reg.ir[15:12] == BTOB_OP_SKIP
                   && (st_reg.rdata & bit_mask) != 8'h00) begin
        st_next.flush = 1'b1;
        st_next.mode = instr.next_two_word ? BTOB_FLUSH2
                                           : BTOB_FLUSH;
      end
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      st_reg <= '{mode: BTOB_EXEC, phase: 2'h0, ir: 16'h0000,
                  rdata: 8'h00, pc: 21'h000000, pc_load: 1'b0,
                  flush: 1'b0};
    end else begin
      st_reg <= st_next;
    end
  end

  // ============================================================
  // outputs
  always_comb begin
    mem = '0;
    if (st_reg.mode == BTOB_EXEC) begin
      mem.addr = op_addr;
      if ((st_reg.ir[15:12] == BTOB_OP_INVERT
           || st_reg.ir[15:12] == BTOB_OP_SKIP)
          && st_reg.phase == BTOB_PHASE_READ) begin
        mem.rd = 1'b1;
      end
      if (st_reg.ir[15:12] == BTOB_OP_INVERT
          && st_reg.phase == BTOB_PHASE_WRITE) begin
        mem.wr = 1'b1;
        mem.wdata = st_reg.rdata ^ bit_mask;
      end
    end
  end

  assign pc_target = st_reg.pc;
  assign pc_load   = st_reg.pc_load;
  assign flush     = st_reg.flush;
  assign phase     = st_reg.phase;
  assign status_we = 1'b0;

  // ============================================================
  // checks
  a_invert_write_data: assert property (
    @(posedge clk_sys) disable iff (reset)
    mem.wr |-> mem.wdata == ($past(mem_rdata, 2) ^ bit_mask))
    else $error("invert data wrong");
  a_bank_sel_addr: assert property (
    @(posedge clk_sys) disable iff (reset)
    (mem.rd && st_reg.ir[8]) |-> mem.addr[11:8] == bank_select_reg)
    else $error("banked address wrong");
  a_access_bank_addr: assert property (
    @(posedge clk_sys) disable iff (reset)
    (mem.rd && !st_reg.ir[8] && !ext_set_en && st_reg.ir[7])
      |-> mem.addr[11:8] == 4'hF)
    else $error("access bank address wrong");
  a_no_branch_clear: assert property (
    @(posedge clk_sys) disable iff (reset)
    (at_decide && !overflow_flag) |=> !pc_load)
    else $error("branch without overflow");
  a_branch_target: assert property (
    @(posedge clk_sys) disable iff (reset)
    (at_decide && is_branch && overflow_flag)
      |=> pc_load && pc_target == $past(pc_in) + 21'd2
          + {{12{$past(st_reg.ir[7])}}, $past(st_reg.ir[7:0]), 1'b0})
    else $error("branch target wrong");
  a_branch_flush_len: assert property (
    @(posedge clk_sys) disable iff (reset)
    $rose(pc_load) |-> flush [*4] ##1 !flush)
    else $error("flush cycle length wrong");
  a_write_phase: assert property (
    @(posedge clk_sys) disable iff (reset)
    mem.wr |-> phase == BTOB_PHASE_WRITE && $past(mem.rd, 2))
    else $error("write not in phase four");
  a_no_status: assert property (
    @(posedge clk_sys) disable iff (reset)
    !status_we)
    else $error("status altered");

  a_read_phase: assert property (
    @(posedge clk_sys) disable iff (reset)
    mem.rd |-> phase == BTOB_PHASE_READ)
    else $error("read not in phase two");
  a_index_addr: assert property (
    @(posedge clk_sys) disable iff (reset)
    (mem.rd && !st_reg.ir[8] && ext_set_en
     && st_reg.ir[7:0] <= BTOB_INDEX_LIMIT) |-> mem.addr[11:8] == 4'h0)
    else $error("indexed address wrong");
  a_access_low_addr: assert property (
    @(posedge clk_sys) disable iff (reset)
    (mem.rd && !st_reg.ir[8] && !ext_set_en
     && st_reg.ir[7:0] < BTOB_ACCESS_SPLIT) |-> mem.addr == {4'h0, st_reg.ir[7:0]})
    else $error("low access address wrong");
  a_bank_low_byte: assert property (
    @(posedge clk_sys) disable iff (reset)
    (mem.rd && st_reg.ir[8]) |-> mem.addr[7:0] == st_reg.ir[7:0])
    else $error("banked low byte wrong");

  a_untaken_single: assert property (
    @(posedge clk_sys) disable iff (reset)
    (at_decide && is_branch && !overflow_flag) |=> !flush)
    else $error("untaken branch flushed");
  a_skip_discard: assert property (
    @(posedge clk_sys) disable iff (reset)
    (at_decide && skip_hit)
      |=> flush)
    else $error("skip did not discard");
  a_skip_long: assert property (
    @(posedge clk_sys) disable iff (reset)
    (at_decide && skip_hit && instr.next_two_word)
      |=> flush [*8] ##1 !flush)
    else $error("long skip length wrong");
  a_skip_short: assert property (
    @(posedge clk_sys) disable iff (reset)
    (at_decide && skip_hit && !instr.next_two_word)
      |=> flush [*4] ##1 !flush)
    else $error("short skip length wrong");
  a_invert_no_flush: assert property (
    @(posedge clk_sys) disable iff (reset)
    (at_decide && is_invert) |=> !flush && !pc_load)
    else $error("invert took extra cycle");
  a_flush_quiet: assert property (
    @(posedge clk_sys) disable iff (reset)
    flush |-> !mem.rd && !mem.wr)
    else $error("memory access in flush");
  a_target_stable: assert property (
    @(posedge clk_sys) disable iff (reset)
    (pc_load && $past(pc_load)) |-> $stable(pc_target))
    else $error("target moved during load");
endmodule

/* File: design/btob_pkg.sv */
// constants and types for the bit invert / overflow branch decoder
// ============================================================
// Summary of operation
// - opcode 0111 bbba ffffffff inverts bit b of the addressed byte
// - bank bit 0 selects the fixed access bank
// - bank bit 1 combines bank select register with file address
// - extended set, bank bit 0, address <= 5Fh uses indexed offset
// - opcode 1110 0100 nnnnnnnn branches only when overflow is 1
// - offset is signed, doubled and added to program counter
// - target is own address plus 2 plus twice the offset
// - taken branch takes two cycles, second a flush; untaken one
// - skip-if-bit-set with tested bit 1 discards next instruction
// - skip over a two word instruction takes three cycles
package btob_pkg;
  // ============================================================
  // encodings
  localparam logic [3:0]  BTOB_OP_INVERT   = 4'h7;
  localparam logic [7:0]  BTOB_OP_BRANCH   = 8'hE4;
  localparam logic [3:0]  BTOB_OP_SKIP     = 4'hA;
  localparam logic [7:0]  BTOB_INDEX_LIMIT = 8'h5F;
  localparam logic [11:0] BTOB_ACCESS_HI   = 12'hF00;
  localparam logic [7:0]  BTOB_ACCESS_SPLIT = 8'h60;
  localparam logic [20:0] BTOB_PC_STEP     = 21'h000002;
  localparam logic [1:0]  BTOB_PHASE_READ  = 2'h1;
  localparam logic [1:0]  BTOB_PHASE_WRITE = 2'h3;
  localparam logic [1:0]  BTOB_PHASE_LAST  = 2'h3;

  typedef enum logic [1:0] {BTOB_EXEC, BTOB_FLUSH, BTOB_FLUSH2} btob_mode_e;

  typedef struct packed {
    logic [15:0] word;
    logic        valid;
    logic        next_two_word;
  } btob_instr_s;

  typedef struct packed {
    logic [11:0] addr;
    logic        rd;
    logic        wr;
    logic [7:0]  wdata;
  } btob_mem_s;

  typedef struct packed {
    btob_mode_e  mode;
    logic [1:0]  phase;
    logic [15:0] ir;
    logic [7:0]  rdata;
    logic [20:0] pc;
    logic        pc_load;
    logic        flush;
  } btob_state_s;
endpackage

/* File: tb/testbench.sv */
// self-checking bench for the bit invert / overflow branch decoder
`timescale 1ns/1ps
module testbench;
  import btob_pkg::*;
  // ============================================================
  // stimulus and observed signals
  logic        clk_sys = 0;
  logic        reset = 1;
  btob_instr_s instr = '0;
  logic [20:0] pc_in = '0, pc_target, pc_v = '0;
  logic [3:0]  bank_select_reg = '0, bsr_v = '0;
  logic [7:0]  fsr2_base = '0, mem_rdata = '0, fsr_v = '0;
  logic        ext_set_en = 0, overflow_flag = 0, ext_v = 0, ovf_v = 0;
  btob_mem_s   mem;
  logic        pc_load, flush, status_we, pl_d = 0;
  logic [1:0]  phase;
  logic [31:0] seed = 32'hD91036F9;
  logic [21:0] q[$];
  int          errors = 0, checks = 0, cycles = 0, hold = 0, n = 0;
  bit          first = 0, busy = 0, two = 0;
  int          fl = 0, fq[$];
  btob_core btob_core_inst (.clk_sys(clk_sys), .reset(reset), .instr(instr),
    .pc_in(pc_in), .bank_select_reg(bank_select_reg),
    .ext_set_en(ext_set_en), .fsr2_base(fsr2_base),
    .overflow_flag(overflow_flag), .mem_rdata(mem_rdata), .mem(mem),
    .pc_target(pc_target), .pc_load(pc_load), .flush(flush),
    .phase(phase), .status_we(status_we));
  always #5 clk_sys = ~clk_sys;
  // ============================================================
  // helpers
  function automatic logic [31:0] rnd();
    seed = {seed[30:0], 1'b0} ^ (seed[31] ? 32'h04C11DB7 : 32'h0);
    return seed;
  endfunction
  task automatic check(string what, logic [21:0] seen, logic [21:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic result(string what, logic [21:0] seen);
    check(what, seen, q.size() > 0 ? q.pop_front() : ~seen);
  endtask
  task automatic conclude();
    if (errors == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // one instruction slot, driven just after the edge ending phase 1
  task automatic slot();
    logic [31:0] r, c;
    logic [15:0] w;
    logic [11:0] a;
    logic [1:0]  k;
    r = rnd();
    c = rnd();
    k = r[1:0];
    w = {BTOB_OP_INVERT, r[15:4]};
    if (c[3:2] == 2'h0) w[7:0] = 8'h5F + {7'h0, c[4]};
    if (hold > 0) begin
      instr <= {w, first, first & two};
      first = 0;
      hold--;
      busy = 0;
    end else begin
      if (!busy) begin
        bsr_v = c[8:5];
        ext_v = c[9];
        fsr_v = {1'b0, c[16:10]};
        ovf_v = c[17];
        pc_v = {c[31:18], r[23:17]};
      end
      if (busy && k[1]) k = 2'h0;
      case (k)
        2'h0: begin
          a = w[8] ? {bsr_v, w[7:0]} : (ext_v && w[7:0] <= 8'h5F) ?
            {4'h0, fsr_v + w[7:0]} : {{4{w[7:0] >= 8'h60}}, w[7:0]};
          q.push_back({2'b00, a, r[31:24] ^ (8'h01 << w[11:9])});
        end
        2'h2: begin
          w = {BTOB_OP_BRANCH, r[11:4]};
          if (ovf_v) begin
            q.push_back({1'b1, pc_v + 21'h2 + {{12{w[7]}}, w[7:0], 1'b0}});
            hold = 2;
            fq.push_back(4);
            first = 1;
          end
        end
        2'h3: begin
          w = {BTOB_OP_SKIP, r[15:4]};
          if (r[24 + w[11:9]]) begin
            hold = c[0] ? 3 : 2;
            two = c[0];
            fq.push_back(c[0] ? 8 : 4);
            first = 1;
          end
        end
        default: ;
      endcase
      instr <= {w, k != 2'h1, c[0]};
      busy = !k[0];
    end
    mem_rdata <= r[31:24];
    bank_select_reg <= bsr_v;
    ext_set_en <= ext_v;
    fsr2_base <= fsr_v;
    overflow_flag <= ovf_v;
    pc_in <= pc_v;
  endtask
  // ============================================================
  // output watcher and run control
  always @(negedge clk_sys) begin
    if (!reset) begin
      check("status_we", {21'h0, status_we}, '0);
      if (mem.wr === 1'b1) begin
        check("phase", {20'h0, phase}, {20'h0, BTOB_PHASE_WRITE});
        result("write", {2'b00, mem.addr, mem.wdata});
      end
      if (pc_load === 1'b1 && pl_d !== 1'b1) begin
        check("flush", {21'h0, flush}, 22'h1);
        result("target", {1'b1, pc_target});
      end
      if (mem.rd === 1'b1) begin
        check("read_phase", {20'h0, phase},
              {20'h0, BTOB_PHASE_READ});
      end
      if (flush === 1'b1) begin
        fl++;
      end else if (fl > 0) begin
        check("flush_len", 22'(fl),
              fq.size() > 0 ? 22'(fq.pop_front()) : '1);
        fl = 0;
      end
      pl_d = pc_load;
    end
  end
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 5000) begin
      errors++;
      conclude();
    end
  end
  initial begin
    repeat (3) @(posedge clk_sys);
    reset <= 0;
    while (n < 300) begin
      @(negedge clk_sys);
      if (phase === 2'h1) begin
        @(posedge clk_sys);
        if (n > 295) hold = 1;
        slot();
        n++;
      end
    end
    repeat (20) @(posedge clk_sys);
    check("pending", 22'(q.size()), '0);
    check("pending_flush", 22'(fq.size()), '0);
    conclude();
  end
endmodule
